// ---- design/timer_capture_top.sv ----
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [15:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [15:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Capture inputs
    input wire logic capture_pin_a,
    input wire logic capture_pin_b,
    input wire logic capture_pin_c,
    input wire logic capture_pin_d,
    input wire logic osc_div128_trigger,
    // Event requests
    output logic [3:0] capture_req,
    output logic overflow_req
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [6:0] ctrl_ab;
        logic [7:0] ctrl_cd;
        logic start;
        logic buf_c;
        logic buf_d;
        logic [15:0] counter;
        logic [15:0] gr_a;
        logic [15:0] gr_b;
        logic [15:0] gr_c;
        logic [15:0] gr_d;
        logic [4:0] status;
        logic [3:0] cap_req;
        logic ovf_req;
        logic aw_got;
        logic w_got;
        logic [15:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    state_s q;
    state_s d;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    // ==========================================================
    // Pin synchronisers and edge selection
    logic a_rise, a_fall, b_rise, b_fall, c_rise, c_fall, d_rise, d_fall;
    logic osc_rise, osc_fall, trig_a_rise, trig_a_fall;
    logic match_a, match_b, match_c, match_d;
    logic mode_a, mode_b, mode_c, mode_d, use_osc;
    logic hit_a, hit_b, hit_c, hit_d;
    logic wr_fire, wr_counter, ovf_event;

    edge_sync u_sync_a (.clk(clk), .reset_n(reset_n), .pin(capture_pin_a),
                        .rise(a_rise), .fall(a_fall));
    edge_sync u_sync_b (.clk(clk), .reset_n(reset_n), .pin(capture_pin_b),
                        .rise(b_rise), .fall(b_fall));
    edge_sync u_sync_c (.clk(clk), .reset_n(reset_n), .pin(capture_pin_c),
                        .rise(c_rise), .fall(c_fall));
    edge_sync u_sync_d (.clk(clk), .reset_n(reset_n), .pin(capture_pin_d),
                        .rise(d_rise), .fall(d_fall));
    edge_sync u_sync_osc (.clk(clk), .reset_n(reset_n), .pin(osc_div128_trigger),
                          .rise(osc_rise), .fall(osc_fall));

    assign mode_a = q.ctrl_ab[timer_capture_pkg::MODE_A_BIT];
    assign mode_b = q.ctrl_ab[timer_capture_pkg::MODE_B_BIT];
    assign mode_c = q.ctrl_cd[timer_capture_pkg::MODE_C_BIT];
    assign mode_d = q.ctrl_cd[timer_capture_pkg::MODE_D_BIT];
    assign use_osc = mode_a && !q.ctrl_ab[timer_capture_pkg::TRIG_SRC_A_BIT];
    assign trig_a_rise = use_osc ? osc_rise : a_rise;
    assign trig_a_fall = use_osc ? osc_fall : a_fall;

    edge_match u_match_a (
        .sel(q.ctrl_ab[timer_capture_pkg::EDGE_A_LSB +: 2]),
        .rise(trig_a_rise), .fall(trig_a_fall), .hit(match_a));
    edge_match u_match_b (
        .sel(q.ctrl_ab[timer_capture_pkg::EDGE_B_LSB +: 2]),
        .rise(b_rise), .fall(b_fall), .hit(match_b));
    edge_match u_match_c (
        .sel(q.ctrl_cd[timer_capture_pkg::EDGE_C_LSB +: 2]),
        .rise(c_rise), .fall(c_fall), .hit(match_c));
    edge_match u_match_d (
        .sel(q.ctrl_cd[timer_capture_pkg::EDGE_D_LSB +: 2]),
        .rise(d_rise), .fall(d_fall), .hit(match_d));

    assign hit_a = match_a && mode_a;
    assign hit_b = match_b && mode_b;
    // Own pins of C and D are ignored while they buffer A and B
    assign hit_c = match_c && mode_c && !q.buf_c;
    assign hit_d = match_d && mode_d && !q.buf_d;

    assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
    assign wr_counter = wr_fire && (q.awaddr == timer_capture_pkg::ADDR_COUNTER)
                        && (|q.wstrb[1:0]);
    assign ovf_event = q.start && (q.counter == timer_capture_pkg::COUNTER_MAX)
                       && !wr_counter;

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.cap_req = 4'h0;
        d.ovf_req = 1'b0;

        if (q.start) begin
            d.counter = 16'(q.counter + 16'h0001);
        end

        // Write address and data are taken in either order
        if (awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = awaddr;
            d.awready = 1'b0;
        end
        if (wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = wdata;
            d.wstrb = wstrb;
            d.wready = 1'b0;
        end
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = timer_capture_pkg::RESP_OKAY;
            case (q.awaddr)
                timer_capture_pkg::ADDR_CTRL_AB: begin
                    if (q.wstrb[0]) begin
                        d.ctrl_ab = q.wdata[6:0];
                    end
                end
                timer_capture_pkg::ADDR_CTRL_CD: begin
                    if (q.wstrb[0]) begin
                        d.ctrl_cd = q.wdata[7:0];
                    end
                end
                timer_capture_pkg::ADDR_MODE: begin
                    if (q.wstrb[0]) begin
                        d.start = q.wdata[timer_capture_pkg::START_BIT];
                        d.buf_c = q.wdata[timer_capture_pkg::BUF_C_BIT];
                        d.buf_d = q.wdata[timer_capture_pkg::BUF_D_BIT];
                    end
                end
                timer_capture_pkg::ADDR_COUNTER: d.counter = merge16(q.counter, q.wdata, q.wstrb);
                timer_capture_pkg::ADDR_STATUS: begin
                    if (q.wstrb[0]) begin
                        d.status = q.status & ~q.wdata[4:0];
                    end
                end
                timer_capture_pkg::ADDR_GR_A: d.gr_a = merge16(q.gr_a, q.wdata, q.wstrb);
                timer_capture_pkg::ADDR_GR_B: d.gr_b = merge16(q.gr_b, q.wdata, q.wstrb);
                timer_capture_pkg::ADDR_GR_C: d.gr_c = merge16(q.gr_c, q.wdata, q.wstrb);
                timer_capture_pkg::ADDR_GR_D: d.gr_d = merge16(q.gr_d, q.wdata, q.wstrb);
                default: d.bresp = timer_capture_pkg::RESP_SLVERR;
            endcase
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end

        // Captures come after bus writes so a capture wins over a write
        if (hit_a) begin
            d.gr_a = q.counter;
            if (q.buf_c) begin
                d.gr_c = q.gr_a;
            end
        end
        if (hit_b) begin
            d.gr_b = q.counter;
            if (q.buf_d) begin
                d.gr_d = q.gr_b;
            end
        end
        if (hit_c) begin
            d.gr_c = q.counter;
        end
        if (hit_d) begin
            d.gr_d = q.counter;
        end
        d.cap_req = {hit_d, hit_c, hit_b, hit_a};
        d.ovf_req = ovf_event;
        // Set after clear, so an event in the clearing cycle is kept
        d.status = d.status | {ovf_event, hit_d, hit_c, hit_b, hit_a};

        if (arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = timer_capture_pkg::RESP_OKAY;
            d.rdata = 32'h0000_0000;
            case (araddr)
                timer_capture_pkg::ADDR_CTRL_AB: d.rdata[7:0] = {1'b1, q.ctrl_ab};
                timer_capture_pkg::ADDR_CTRL_CD: d.rdata[7:0] = q.ctrl_cd;
                timer_capture_pkg::ADDR_MODE: begin
                    d.rdata[timer_capture_pkg::START_BIT] = q.start;
                    d.rdata[timer_capture_pkg::BUF_C_BIT] = q.buf_c;
                    d.rdata[timer_capture_pkg::BUF_D_BIT] = q.buf_d;
                end
                timer_capture_pkg::ADDR_COUNTER: d.rdata[15:0] = q.counter;
                timer_capture_pkg::ADDR_STATUS: d.rdata[4:0] = q.status;
                timer_capture_pkg::ADDR_GR_A: d.rdata[15:0] = q.gr_a;
                timer_capture_pkg::ADDR_GR_B: d.rdata[15:0] = q.gr_b;
                timer_capture_pkg::ADDR_GR_C: d.rdata[15:0] = q.gr_c;
                timer_capture_pkg::ADDR_GR_D: d.rdata[15:0] = q.gr_d;
                default: d.rresp = timer_capture_pkg::RESP_SLVERR;
            endcase
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end

        if (!reset_n) begin
            d = '0;
            d.ctrl_ab = timer_capture_pkg::CTRL_AB_RST[6:0];
            d.ctrl_cd = timer_capture_pkg::CTRL_CD_RST;
            d.counter = timer_capture_pkg::COUNTER_RST;
            d.awready = 1'b1;
            d.wready = 1'b1;
            d.arready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // ==========================================================
    // Outputs
    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign capture_req = q.cap_req;
    assign overflow_req = q.ovf_req;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic wr_gr_a;
    assign wr_gr_a = wr_fire && (q.awaddr == timer_capture_pkg::ADDR_GR_A);

    a_bit7_reads_one: assert property (
        arvalid && arready && (araddr == timer_capture_pkg::ADDR_CTRL_AB)
        |=> rvalid && rdata[7] && (rdata[6:0] == $past(q.ctrl_ab)))
        else $error("control bit 7 did not read as one");

    a_counter_runs: assert property (
        q.start && !wr_counter |=> q.counter == 16'($past(q.counter) + 16'h0001))
        else $error("running counter did not step by one");

    a_counter_holds: assert property (
        !q.start && !wr_counter |=> $stable(q.counter))
        else $error("stopped counter changed");

    a_capture_a_value: assert property (
        hit_a |=> q.gr_a == $past(q.counter))
        else $error("channel A did not capture the counter");

    a_buffer_c_moves: assert property (
        hit_a && q.buf_c |=> q.gr_c == $past(q.gr_a))
        else $error("channel C did not take the old A value");

    a_buffer_c_holds: assert property (
        q.buf_c && !hit_a && !(wr_fire && (q.awaddr == timer_capture_pkg::ADDR_GR_C))
        |=> $stable(q.gr_c))
        else $error("buffered channel C changed without an A capture");

    a_forbidden_edge: assert property (
        (q.ctrl_ab[1:0] == 2'h3) && !wr_gr_a [*2] |=> $stable(q.gr_a))
        else $error("channel A captured with forbidden edge code");

    a_mode_gates_b: assert property (
        !mode_b && match_b |-> !hit_b ##1 !capture_req[1])
        else $error("channel B captured with mode bit clear");

    a_osc_source: assert property (
        !mode_a |-> (trig_a_rise == a_rise) && (trig_a_fall == a_fall))
        else $error("oscillator trigger used while mode bit clear");

    a_event_req: assert property (
        hit_a |=> capture_req[0] && q.status[0] ##1 !capture_req[0] || hit_a)
        else $error("capture request not pulsed for one cycle");

    a_overflow_req: assert property (
        ovf_event |=> overflow_req && (q.counter == 16'h0000)
        && q.status[timer_capture_pkg::OVF_FLAG_BIT])
        else $error("overflow request or wrap missing");

    a_write_answer: assert property (
        wr_fire |=> bvalid && !awready && !wready)
        else $error("write response not raised after both halves");

    c_capture_a: cover property (hit_a ##1 capture_req[0]);
    c_buffer_move: cover property (q.buf_c && hit_a);
    c_overflow: cover property (ovf_event);
    c_both_edges: cover property ((q.ctrl_cd[5:4] == 2'h2) && hit_d);
endmodule : timer_capture_top
`default_nettype wire

// ---- design/timer_capture_pkg.sv ----
`default_nettype none
package timer_capture_pkg;

    // ==========================================================
    // Register indexes and byte addresses
    localparam logic [15:0] IDX_CTRL_AB = 16'h0124;
    localparam logic [15:0] IDX_CTRL_CD = 16'h0125;
    localparam logic [15:0] ADDR_CTRL_AB = {IDX_CTRL_AB[13:0], 2'b00};
    localparam logic [15:0] ADDR_CTRL_CD = {IDX_CTRL_CD[13:0], 2'b00};
    localparam logic [15:0] ADDR_MODE = 16'h0500;
    localparam logic [15:0] ADDR_COUNTER = 16'h0504;
    localparam logic [15:0] ADDR_STATUS = 16'h0508;
    localparam logic [15:0] ADDR_GR_A = 16'h0510;
    localparam logic [15:0] ADDR_GR_B = 16'h0514;
    localparam logic [15:0] ADDR_GR_C = 16'h0518;
    localparam logic [15:0] ADDR_GR_D = 16'h051C;

    // ==========================================================
    // Field positions
    localparam int EDGE_A_LSB = 0;
    localparam int MODE_A_BIT = 2;
    localparam int TRIG_SRC_A_BIT = 3;
    localparam int EDGE_B_LSB = 4;
    localparam int MODE_B_BIT = 6;
    localparam int UNUSED_AB_BIT = 7;
    localparam int EDGE_C_LSB = 0;
    localparam int MODE_C_BIT = 2;
    localparam int FUNC_C_BIT = 3;
    localparam int EDGE_D_LSB = 4;
    localparam int MODE_D_BIT = 6;
    localparam int FUNC_D_BIT = 7;
    localparam int START_BIT = 0;
    localparam int BUF_C_BIT = 1;
    localparam int BUF_D_BIT = 2;
    localparam int OVF_FLAG_BIT = 4;

    // ==========================================================
    // Values after reset, and the counter maximum
    localparam logic [7:0] CTRL_AB_RST = 8'h88;
    localparam logic [7:0] CTRL_CD_RST = 8'h00;
    localparam logic [15:0] COUNTER_RST = 16'h0000;
    localparam logic [15:0] COUNTER_MAX = 16'hFFFF;

    // ==========================================================
    // Encodings
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timer_capture_pkg
`default_nettype wire

// ---- design/edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Asynchronous level
    input wire logic pin,
    // Registered edge pulses
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic primed;
        logic level;
        logic rise;
        logic fall;
    } sync_s;

    sync_s q;
    sync_s d;

    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = 1'b0;
        d.fall = 1'b0;
        // First agreement only loads the level, so a pin high at reset is no edge
        if (q.s2 == q.s3) begin
            d.primed = 1'b1;
            d.level = q.s3;
            if (q.primed && (q.s3 != q.level)) begin
                d.rise = q.s3;
                d.fall = ~q.s3;
            end
        end
        // Chain keeps filling in reset, so the first level seen is the real pin
        if (!reset_n) begin
            d = '0;
            d.s1 = pin;
            d.s2 = q.s1;
            d.s3 = q.s2;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign rise = q.rise;
    assign fall = q.fall;
endmodule : edge_sync
`default_nettype wire

// ---- design/edge_match.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_match (
    // Edge select field
    input wire logic [1:0] sel,
    // Edge pulses
    input wire logic rise,
    input wire logic fall,
    // Valid edge seen
    output logic hit
);
    always_comb begin
        case (sel)
            timer_capture_pkg::EDGE_RISE: hit = rise;
            timer_capture_pkg::EDGE_FALL: hit = fall;
            timer_capture_pkg::EDGE_BOTH: hit = rise | fall;
            // Forbidden code captures nothing
            default: hit = 1'b0;
        endcase
    end
endmodule : edge_match
`default_nettype wire

// ---- verif/pin_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
    parameter int SKEW_NS = 7
) (
    // Clock
    input wire logic clk,
    // Wanted levels, bit 4 is the divided oscillator
    input wire logic [4:0] want,
    // Capture pins
    output logic capture_pin_a,
    output logic capture_pin_b,
    output logic capture_pin_c,
    output logic capture_pin_d,
    output logic osc_div128_trigger
);
    // ==========================================================
    // Pin levels
    logic [4:0] lvl = 5'h00;

    // Skewed off the edge so the synchronisers see a truly asynchronous change
    always @(posedge clk) begin
        lvl <= #(SKEW_NS) want;
    end

    assign capture_pin_a = lvl[0];
    assign capture_pin_b = lvl[1];
    assign capture_pin_c = lvl[2];
    assign capture_pin_d = lvl[3];
    assign osc_div128_trigger = lvl[4];
endmodule : pin_source
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic [1:0] resp;
    } row_s;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, overflow_req;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [3:0] capture_req;
    logic [4:0] want = 5'h00;
    logic pa, pb, pc, pd, posc;
    logic [7:0] cap_cnt [4] = '{default: 8'h00};
    logic [7:0] ovf_cnt = 8'h00;
    int n_errors = 0, n_tests = 0;
    localparam row_s rows [7] = '{
        '{timer_capture_pkg::ADDR_CTRL_AB, 32'h0000_00FF, 32'h0000_00FF, 2'h0},
        '{timer_capture_pkg::ADDR_CTRL_AB, 32'h0000_0077, 32'h0000_00F7, 2'h0},
        '{timer_capture_pkg::ADDR_CTRL_AB, 32'h0000_0000, 32'h0000_0080, 2'h0},
        '{timer_capture_pkg::ADDR_CTRL_CD, 32'h0000_00FF, 32'h0000_00FF, 2'h0},
        '{timer_capture_pkg::ADDR_CTRL_CD, 32'h0000_00A5, 32'h0000_00A5, 2'h0},
        '{timer_capture_pkg::ADDR_GR_B, 32'h0000_BEEF, 32'h0000_BEEF, 2'h0},
        '{16'h0600, 32'h0000_0001, 32'h0000_0000, 2'h2}};

    always #12.5 clk = ~clk;

    timer_capture_top uut (.clk(clk), .reset_n(reset_n),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .capture_pin_a(pa), .capture_pin_b(pb), .capture_pin_c(pc), .capture_pin_d(pd),
        .osc_div128_trigger(posc), .capture_req(capture_req), .overflow_req(overflow_req));

    pin_source src (.clk(clk), .want(want), .capture_pin_a(pa), .capture_pin_b(pb),
        .capture_pin_c(pc), .capture_pin_d(pd), .osc_div128_trigger(posc));

    // ==========================================================
    // Event counters, frozen in reset so power-up unknowns never leak in
    always @(posedge clk) begin
        if (reset_n) begin
            for (int i = 0; i < 4; i++) begin
                cap_cnt[i] <= cap_cnt[i] + 8'(capture_req[i]);
            end
            ovf_cnt <= ovf_cnt + 8'(overflow_req);
        end
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bus_wr(input logic [15:0] addr, input logic [31:0] data);
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= addr;
        wvalid <= 1'b1;
        wdata <= data;
        bready <= 1'b1;
        // No wait limit here: only the watchdog ends a hung transfer
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [15:0] addr);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= addr;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : bus_rd

    // Levels held 8 clocks, well past the two-clock minimum and one clock past the 7-clock latency to the event counters
    task automatic pins(input logic [4:0] lv);
        @(posedge clk);
        want <= lv;
        repeat (8) @(posedge clk);
    endtask : pins

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Sequence
    initial begin
        logic [7:0] base [4];
        logic [7:0] ob;
        logic [31:0] held;
        logic [1:0] code;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            bus_wr(rows[i].addr, rows[i].wdata);
            check(32'(rs), 32'(rows[i].resp));
            bus_rd(rows[i].addr);
            check(rd, rows[i].exp);
            check(32'(rs), 32'(rows[i].resp));
        end
        for (int c = 0; c < 4; c++) begin
            code = 2'(c);
            bus_wr(timer_capture_pkg::ADDR_CTRL_AB, {24'h0, 2'b01, code, 2'b11, code});
            bus_wr(timer_capture_pkg::ADDR_CTRL_CD, {24'h0, 2'b11, code, 2'b11, code});
            base = cap_cnt;
            pins(5'h0F);
            for (int j = 0; j < 4; j++) begin
                check(32'(cap_cnt[j] - base[j]), 32'((c == 0 || c == 2) ? 1 : 0));
            end
            base = cap_cnt;
            pins(5'h00);
            for (int j = 0; j < 4; j++) begin
                check(32'(cap_cnt[j] - base[j]), 32'((c == 1 || c == 2) ? 1 : 0));
            end
        end
        // Channel A on the divided oscillator, then on its pin, then disabled
        bus_wr(timer_capture_pkg::ADDR_CTRL_AB, 32'h0000_0004);
        base = cap_cnt;
        pins(5'h01);
        pins(5'h00);
        check(32'(cap_cnt[0] - base[0]), 32'h0000_0000);
        pins(5'h10);
        pins(5'h00);
        check(32'(cap_cnt[0] - base[0]), 32'h0000_0001);
        bus_wr(timer_capture_pkg::ADDR_CTRL_AB, 32'h0000_000C);
        pins(5'h10);
        pins(5'h00);
        check(32'(cap_cnt[0] - base[0]), 32'h0000_0001);
        bus_wr(timer_capture_pkg::ADDR_CTRL_AB, 32'h0000_0000);
        pins(5'h13);
        pins(5'h00);
        check(32'(cap_cnt[0] - base[0]), 32'h0000_0001);
        check(32'(cap_cnt[1] - base[1]), 32'h0000_0000);
        // Captured value with the counter stopped, then buffer transfer
        bus_wr(timer_capture_pkg::ADDR_MODE, 32'h0000_0000);
        bus_wr(timer_capture_pkg::ADDR_COUNTER, 32'h0000_1234);
        bus_wr(timer_capture_pkg::ADDR_CTRL_AB, 32'h0000_004C);
        pins(5'h03);
        pins(5'h00);
        bus_rd(timer_capture_pkg::ADDR_GR_A);
        check(rd, 32'h0000_1234);
        bus_rd(timer_capture_pkg::ADDR_GR_B);
        check(rd, 32'h0000_1234);
        bus_wr(timer_capture_pkg::ADDR_MODE, 32'h0000_0006);
        bus_wr(timer_capture_pkg::ADDR_CTRL_CD, 32'h0000_00CC);
        bus_wr(timer_capture_pkg::ADDR_COUNTER, 32'h0000_5678);
        pins(5'h0C);
        pins(5'h00);
        bus_rd(timer_capture_pkg::ADDR_GR_C);
        check(rd, 32'h0000_0000);
        bus_rd(timer_capture_pkg::ADDR_GR_D);
        check(rd, 32'h0000_0000);
        pins(5'h03);
        pins(5'h00);
        bus_rd(timer_capture_pkg::ADDR_GR_A);
        check(rd, 32'h0000_5678);
        bus_rd(timer_capture_pkg::ADDR_GR_C);
        check(rd, 32'h0000_1234);
        bus_rd(timer_capture_pkg::ADDR_GR_B);
        check(rd, 32'h0000_5678);
        bus_rd(timer_capture_pkg::ADDR_GR_D);
        check(rd, 32'h0000_1234);
        // Overflow across the wrap, then the count must hold once stopped
        bus_wr(timer_capture_pkg::ADDR_COUNTER, 32'h0000_FFF0);
        ob = ovf_cnt;
        bus_wr(timer_capture_pkg::ADDR_MODE, 32'h0000_0001);
        repeat (30) @(posedge clk);
        bus_wr(timer_capture_pkg::ADDR_MODE, 32'h0000_0000);
        check(32'(ovf_cnt - ob), 32'h0000_0001);
        bus_rd(timer_capture_pkg::ADDR_COUNTER);
        held = rd;
        repeat (10) @(posedge clk);
        bus_rd(timer_capture_pkg::ADDR_COUNTER);
        check(rd, held);
        // Second reset in mid-run
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        bus_rd(timer_capture_pkg::ADDR_CTRL_AB);
        check(rd, 32'h0000_0088);
        bus_rd(timer_capture_pkg::ADDR_CTRL_CD);
        check(rd, 32'h0000_0000);
        bus_rd(timer_capture_pkg::ADDR_COUNTER);
        check(rd, 32'h0000_0000);
        wrap_up();
    end

    // Run needs a few hundred clocks; 40000 leaves ample margin
    initial begin
        #1_000_000;
        n_errors++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
